// ==== bca_core.sv ====
/*
 * Branch condition and 8-bit adder with an Avalon-MM register slave.
 * Assumes one synchronous clock and a master that holds each request
 * until waitrequest is seen low.
 */
// What this block does
// - jump taken only when condition field true
// - conditions use only carry, zero, sign, overflow
// - codes 6/E test zero set/clear
// - codes 7/F test carry set/clear
// - codes 9/1/A/2 signed compare via s xor v
// - code B carry and zero clear; 3 either
// - add with carry writes dst, keeps src
// - carry chains into next higher byte add
// - plain add writes dst, no carry in
// - carry set on carry out of bit 7
// - zero set when result is zero
// - sign follows result bit 7
// - overflow: same-sign operands, opposite-sign result
// - add with carry: half carry from bit 3
// - plain add: half carry from low nibble
`timescale 1ns/1ps
`include "bca_cfg.svh"

module bca_core (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    output bca_pkg::bca_flags_s      flagsOut,
    output logic                     jumpTaken,
    output logic                     execBusy
);

    // ************************************************************
    // functions
    // ************************************************************
    function automatic bca_pkg::bca_op_e opClass(input logic [7:0] op);
        logic hiAdd;
        logic hiAdc;
        logic loArith;
        hiAdd   = op[7:4] == `BCA_HI_ADD;
        hiAdc   = op[7:4] == `BCA_HI_ADC;
        loArith = (op[3:0] >= `BCA_LO_RR) && (op[3:0] <= `BCA_LO_IMM);
        if (hiAdd && loArith) begin
            return bca_pkg::BCA_OP_ADD;
        end else if (hiAdc && loArith) begin
            return bca_pkg::BCA_OP_ADC;
        end else if (op[3:0] == `BCA_LO_REL || op[3:0] == `BCA_LO_DIR) begin
            return bca_pkg::BCA_OP_JMP;
        end else begin
            return bca_pkg::BCA_OP_BAD;
        end
    endfunction : opClass

    // cycles still to wait after the accepting edge
    function automatic logic [2:0] cycLeft(input logic [3:0] lo,
                                           input bca_pkg::bca_op_e cls);
        case (cls)
            bca_pkg::BCA_OP_ADD,
            bca_pkg::BCA_OP_ADC: begin
                if (lo == `BCA_LO_RR) begin
                    return 3'(`BCA_CYC_SHORT - 1);
                end else begin
                    return 3'(`BCA_CYC_LONG - 1);
                end
            end
            bca_pkg::BCA_OP_JMP: return 3'(`BCA_CYC_JMP - 1);
            default:             return 3'(`BCA_CYC_BAD - 1);
        endcase
    endfunction : cycLeft

    function automatic bca_pkg::bca_sum_s add8(input logic [7:0] a,
                                               input logic [7:0] b,
                                               input logic       cin);
        logic [8:0]        full;
        logic [4:0]        low;
        bca_pkg::bca_sum_s r;
        full    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.res   = full[7:0];
        r.flg.c = full[8];
        r.flg.z = full[7:0] == 8'h00;
        r.flg.s = full[7];
        r.flg.v = (a[7] == b[7]) && (full[7] != a[7]);
        r.flg.d = 1'b0;
        r.flg.h = low[4];
        return r;
    endfunction : add8

    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0]          dst_ff;
    logic [7:0]          src_ff;
    bca_pkg::bca_flags_s flags_ff;
    logic [7:0]          opcode_ff;
    logic                taken_ff;
    logic                bad_ff;
    logic                jmp_ff;
    logic [2:0]          cnt_ff;
    logic                rdPend_ff;
    logic [31:0]         rdData_ff;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire hitOpnd = avs_address == `BCA_OFS_OPND;
    wire hitFlag = avs_address == `BCA_OFS_FLAG;
    wire hitCmd  = avs_address == `BCA_OFS_CMD;
    wire hitStat = avs_address == `BCA_OFS_STAT;
    wire busy    = cnt_ff != 3'h0;
    wire wrTake  = avs_write & ~busy;
    // reads always take at least one wait cycle so read data comes from a flop
    wire rdStart = avs_read & ~busy & ~rdPend_ff;
    wire cmdGo   = wrTake & hitCmd & avs_byteenable[0];
    wire wrDst   = wrTake & hitOpnd & avs_byteenable[0];
    wire wrSrc   = wrTake & hitOpnd & avs_byteenable[1];
    wire wrFlag  = wrTake & hitFlag & avs_byteenable[0];

    assign avs_waitrequest = busy | (avs_read & ~rdPend_ff);
    assign avs_readdata    = rdData_ff;
    assign flagsOut        = flags_ff;
    assign jumpTaken       = taken_ff;
    assign execBusy        = busy;

    // ************************************************************
    // execution
    // ************************************************************
    wire bca_pkg::bca_op_e  opNow  = opClass(avs_writedata[7:0]);
    wire bca_pkg::bca_cc_t  ccNow  = avs_writedata[7:4];
    wire                    isAdc  = opNow == bca_pkg::BCA_OP_ADC;
    wire                    execAdd = cmdGo & (isAdc | (opNow == bca_pkg::BCA_OP_ADD));
    wire                    execJmp = cmdGo & (opNow == bca_pkg::BCA_OP_JMP);
    // carry-in only for add with carry; it is the stored carry, so bytes chain
    wire                    cinNow = isAdc & flags_ff.c;
    wire bca_pkg::bca_sum_s sumNow = add8(dst_ff, src_ff, cinNow);
    wire                    condTrue;

    bca_cond_eval u_cond (
        .branchConditionField (ccNow),
        .flags                (flags_ff),
        .condTrue             (condTrue)
    );

    // ************************************************************
    // next values
    // ************************************************************
    wire [7:0] nxt_dst = execAdd ? sumNow.res :
                         wrDst ? avs_writedata[7:0] : dst_ff;
    // source is never written by an add
    wire [7:0] nxt_src = wrSrc ? avs_writedata[15:8] : src_ff;
    wire bca_pkg::bca_flags_s nxt_flags =
        execAdd ? sumNow.flg :
        wrFlag  ? bca_pkg::bca_flags_s'(avs_writedata[5:0]) : flags_ff;
    wire [7:0] nxt_opcode = cmdGo ? avs_writedata[7:0] : opcode_ff;
    wire       nxt_taken  = execJmp ? condTrue :
                            cmdGo ? 1'b0 : taken_ff;
    wire       nxt_bad    = cmdGo ? (opNow == bca_pkg::BCA_OP_BAD) : bad_ff;
    wire       nxt_jmp    = cmdGo ? (opNow == bca_pkg::BCA_OP_JMP) : jmp_ff;
    wire [2:0] nxt_cnt    = cmdGo ? cycLeft(avs_writedata[3:0], opNow) :
                            busy ? cnt_ff - 3'h1 : cnt_ff;
    wire [31:0] rdMux =
        hitOpnd ? 32'({src_ff, dst_ff}) :
        hitFlag ? 32'(flags_ff) :
        hitCmd  ? 32'(opcode_ff) :
        hitStat ? 32'({jmp_ff, bad_ff, taken_ff, busy}) : 32'h0000_0000;
    wire [31:0] nxt_rdData = rdStart ? rdMux : rdData_ff;

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dst_ff    <= `BCA_OPND_RST;
            src_ff    <= `BCA_OPND_RST;
            flags_ff  <= `BCA_FLAG_RST;
            opcode_ff <= `BCA_CMD_RST;
        end else begin
            dst_ff    <= nxt_dst;
            src_ff    <= nxt_src;
            flags_ff  <= nxt_flags;
            opcode_ff <= nxt_opcode;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            taken_ff  <= 1'b0;
            bad_ff    <= 1'b0;
            jmp_ff    <= 1'b0;
            cnt_ff    <= 3'h0;
            rdPend_ff <= 1'b0;
            rdData_ff <= 32'h0000_0000;
        end else begin
            taken_ff  <= nxt_taken;
            bad_ff    <= nxt_bad;
            jmp_ff    <= nxt_jmp;
            cnt_ff    <= nxt_cnt;
            rdPend_ff <= rdStart;
            rdData_ff <= nxt_rdData;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    wire [8:0] sumRef  = {1'b0, dst_ff} + {1'b0, src_ff} + {8'h00, cinNow};
    wire [4:0] nibRef  = {1'b0, dst_ff[3:0]} + {1'b0, src_ff[3:0]} + {4'h0, cinNow};
    wire       halfRef = nibRef[4];
    wire       rrForm  = avs_writedata[3:0] == `BCA_LO_RR;

    sum_carry_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd |=> {flags_ff.c, dst_ff} == $past(sumRef))
        else $error("sum or carry wrong after add");

    src_kept_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd |=> src_ff == $past(src_ff))
        else $error("source changed by add");

    zero_flag_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd |=> flags_ff.z == (dst_ff == 8'h00))
        else $error("zero flag wrong after add");

    sign_flag_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd |=> flags_ff.s == dst_ff[7])
        else $error("sign flag wrong after add");

    wrap_flag_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd |=> flags_ff.v == (($past(dst_ff[7]) == $past(src_ff[7]))
                                   && (dst_ff[7] != $past(dst_ff[7]))))
        else $error("overflow flag wrong after add");

    decimal_clear_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd |=> !flags_ff.d)
        else $error("decimal flag not cleared");

    half_carry_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd |=> flags_ff.h == $past(halfRef))
        else $error("half carry wrong after add");

    plain_nocarry_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd && !isAdc |=> dst_ff == $past(dst_ff) + $past(src_ff))
        else $error("plain add used carry in");

    plain_half_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd && !isAdc |=> flags_ff.h ==
            (({1'b0, $past(dst_ff[3:0])} + {1'b0, $past(src_ff[3:0])}) > 5'h0F))
        else $error("plain add half carry wrong");

    short_cycles_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execAdd && rrForm |=> avs_waitrequest [*3] ##1 !busy)
        else $error("register form not four cycles");

    zero_cond_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execJmp && ccNow == `BCA_CC_OPERANDS_MATCH |=> jumpTaken == flags_ff.z)
        else $error("zero condition wrong");

    carry_cond_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execJmp && ccNow == `BCA_CC_UNSIGNED_AT_LEAST |=> jumpTaken == !flags_ff.c)
        else $error("no-carry condition wrong");

    signed_cond_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execJmp && ccNow == `BCA_CC_SIGNED_ABOVE
        |=> jumpTaken == !(flags_ff.z | (flags_ff.s ^ flags_ff.v)))
        else $error("signed above condition wrong");

    unsigned_cond_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execJmp && ccNow == `BCA_CC_UNSIGNED_ABOVE
        |=> jumpTaken == (!flags_ff.c && !flags_ff.z))
        else $error("unsigned above condition wrong");

    never_cond_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        execJmp && ccNow == `BCA_CC_NEVER |=> !jumpTaken [*4])
        else $error("never condition jumped");

    read_answer_a:
    assert property (@(posedge clk) disable iff (!rst_b)
        rdStart |=> !avs_waitrequest && avs_readdata == $past(rdMux))
        else $error("read answer late or wrong");

endmodule : bca_core

// ==== bca_cfg.svh ====
/*
 * Offsets, field positions, reset values, opcode fields and cycle counts
 * of the branch condition and adder block.
 * Assumes byte addresses on the register bus, one aligned word per register.
 */
`ifndef BCA_CFG_SVH
`define BCA_CFG_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define BCA_OFS_OPND    4'h0
`define BCA_OFS_FLAG    4'h4
`define BCA_OFS_CMD     4'h8
`define BCA_OFS_STAT    4'hC

// ************************************************************
// field positions and reset values
// ************************************************************
`define BCA_STAT_BUSY   0
`define BCA_STAT_TAKEN  1
`define BCA_STAT_BAD    2
`define BCA_STAT_JMP    3
`define BCA_OPND_RST    8'h00
`define BCA_FLAG_RST    6'h00
`define BCA_CMD_RST     8'h00

// ************************************************************
// opcode fields
// ************************************************************
`define BCA_HI_ADD      4'h0
`define BCA_HI_ADC      4'h1
`define BCA_LO_RR       4'h2
`define BCA_LO_IMM      4'h6
`define BCA_LO_REL      4'hB
`define BCA_LO_DIR      4'hD

// ************************************************************
// condition codes
// ************************************************************
`define BCA_CC_NEVER            4'h0
`define BCA_CC_SIGNED_BELOW     4'h1
`define BCA_CC_SIGNED_AT_MOST   4'h2
`define BCA_CC_UNSIGNED_AT_MOST 4'h3
`define BCA_CC_SIGNED_WRAP      4'h4
`define BCA_CC_NEGATIVE         4'h5
`define BCA_CC_OPERANDS_MATCH   4'h6
`define BCA_CC_UNSIGNED_BELOW   4'h7
`define BCA_CC_ALWAYS           4'h8
`define BCA_CC_SIGNED_AT_LEAST  4'h9
`define BCA_CC_SIGNED_ABOVE     4'hA
`define BCA_CC_UNSIGNED_ABOVE   4'hB
`define BCA_CC_NO_SIGNED_WRAP   4'hC
`define BCA_CC_POSITIVE         4'hD
`define BCA_CC_MISMATCH         4'hE
`define BCA_CC_UNSIGNED_AT_LEAST 4'hF

// ************************************************************
// instruction lengths in clock cycles
// ************************************************************
`define BCA_CYC_SHORT   4
`define BCA_CYC_LONG    6
`define BCA_CYC_JMP     4
`define BCA_CYC_BAD     1

`endif

// ==== bca_pkg.sv ====
/*
 * Types shared by the branch condition and adder block.
 * Assumes nothing of its surroundings.
 */
package bca_pkg;

    typedef logic [3:0] bca_cc_t;

    // bit 0 is carry, bit 5 is half carry
    typedef struct packed {
        logic h;
        logic d;
        logic v;
        logic s;
        logic z;
        logic c;
    } bca_flags_s;

    typedef struct packed {
        logic [7:0] res;
        bca_flags_s flg;
    } bca_sum_s;

    typedef enum logic [1:0] {
        BCA_OP_ADD,
        BCA_OP_ADC,
        BCA_OP_JMP,
        BCA_OP_BAD
    } bca_op_e;

endpackage : bca_pkg

// ==== bca_cond_eval.sv ====
/*
 * Branch condition evaluator: one 4-bit condition field against the flags.
 * Assumes the flags come from a register on the caller's clock.
 */
`timescale 1ns/1ps
`include "bca_cfg.svh"

module bca_cond_eval (
    input  wire bca_pkg::bca_cc_t    branchConditionField,
    input  wire bca_pkg::bca_flags_s flags,
    output logic                     condTrue
);

    // only c, z, s and v are looked at
    wire signedLess = flags.s ^ flags.v;

    always_comb begin
        case (branchConditionField)
            `BCA_CC_NEVER:             condTrue = 1'b0;
            `BCA_CC_ALWAYS:            condTrue = 1'b1;
            `BCA_CC_UNSIGNED_BELOW:    condTrue = flags.c;
            `BCA_CC_UNSIGNED_AT_LEAST: condTrue = ~flags.c;
            `BCA_CC_OPERANDS_MATCH:    condTrue = flags.z;
            `BCA_CC_MISMATCH:          condTrue = ~flags.z;
            `BCA_CC_POSITIVE:          condTrue = ~flags.s;
            `BCA_CC_NEGATIVE:          condTrue = flags.s;
            `BCA_CC_SIGNED_WRAP:       condTrue = flags.v;
            `BCA_CC_NO_SIGNED_WRAP:    condTrue = ~flags.v;
            `BCA_CC_SIGNED_AT_LEAST:   condTrue = ~signedLess;
            `BCA_CC_SIGNED_BELOW:      condTrue = signedLess;
            `BCA_CC_SIGNED_ABOVE:      condTrue = ~(flags.z | signedLess);
            `BCA_CC_SIGNED_AT_MOST:    condTrue = flags.z | signedLess;
            `BCA_CC_UNSIGNED_ABOVE:    condTrue = ~flags.c & ~flags.z;
            `BCA_CC_UNSIGNED_AT_MOST:  condTrue = flags.c | flags.z;
            default:                   condTrue = 1'b0;
        endcase
    end

endmodule : bca_cond_eval

// ==== bca_seq_model.sv ====
/*
 * Avalon-MM master that stands in for the instruction sequencer.
 * Assumes the slave answers through waitrequest on the same clock.
 */
`timescale 1ns/1ps

module bca_seq_model (
    input  wire logic        clk,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic [3:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    output logic             hung    // high while an access waits for its answer
);
    initial begin
        avs_address    = 4'hF;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'hA5A5_A5A5;
        avs_byteenable = 4'h0;
        hung           = 1'b0;
    end

    // ************************************************************
    // one access, entered just after a rising edge
    // ************************************************************
    task automatic xfer(
        input  logic        wr,
        input  logic [3:0]  addr,
        input  logic [31:0] wdata,
        input  logic [3:0]  be,
        output logic [31:0] rdata
    );
        hung           <= 1'b1;
        avs_address    <= addr;
        avs_read       <= ~wr;
        avs_write      <= wr;
        avs_writedata  <= wdata;
        avs_byteenable <= be;
        // no cycle limit here: only the bench timeout may end a wait
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        hung <= 1'b0;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // released lines show garbage, so idle decoding cannot pass by luck
        avs_address   <= ~addr;
        avs_writedata <= ~wdata;
        @(posedge clk);
    endtask : xfer
endmodule : bca_seq_model

// ==== bca_core_tb.sv ====
/*
 * Self-checking bench of the branch condition and adder block.
 * Assumes the sequencer model owns the register bus.
 */
`timescale 1ns/1ps
`include "bca_cfg.svh"

module bca_core_tb;
    logic                clk = 1'b0;
    logic                rst_b = 1'b0;
    logic [3:0]          avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [31:0]         avs_writedata;
    logic [3:0]          avs_byteenable;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    bca_pkg::bca_flags_s flagsOut;
    logic                jumpTaken;
    logic                execBusy;
    logic                seqHung;
    int                  fail_count = 0;
    int                  checks = 0;
    int                  seed = 32'hff87_f9c8;
    int                  busyCycles = 0;
    int                  cycles = 0;

    bca_core dut_u (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flagsOut(flagsOut),
        .jumpTaken(jumpTaken), .execBusy(execBusy));

    bca_seq_model seq_u (.clk(clk), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .hung(seqHung));

    initial begin
        forever #20 clk = ~clk;
    end

    // busy length is measured as a running total, compared per command
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (execBusy === 1'b1) begin
            busyCycles <= busyCycles + 1;
        end
        if (cycles == 20000) begin
            fail_count++;
            $display("[ERR] %0t run took too long", $time);
            report_and_stop();
        end
    end

    // ************************************************************
    // expectations
    // ************************************************************
    function automatic bca_pkg::bca_sum_s addExp(input logic [7:0] a, input logic [7:0] b,
                                                 input logic cin);
        bca_pkg::bca_sum_s r;
        logic [8:0]        full;
        logic [4:0]        low;
        full    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.res   = full[7:0];
        r.flg.c = full[8];
        r.flg.z = (full[7:0] == 8'h00);
        r.flg.s = full[7];
        r.flg.v = (a[7] == b[7]) && (full[7] != a[7]);
        r.flg.d = 1'b0;
        r.flg.h = low[4];
        return r;
    endfunction : addExp

    function automatic logic condExp(input logic [3:0] cc, input bca_pkg::bca_flags_s f);
        logic sv;
        sv = f.s ^ f.v;
        case (cc)
            4'h0: condExp = 1'b0;
            4'h8: condExp = 1'b1;
            4'h7: condExp = f.c;
            4'hF: condExp = ~f.c;
            4'h6: condExp = f.z;
            4'hE: condExp = ~f.z;
            4'hD: condExp = ~f.s;
            4'h5: condExp = f.s;
            4'h4: condExp = f.v;
            4'hC: condExp = ~f.v;
            4'h9: condExp = ~sv;
            4'h1: condExp = sv;
            4'hA: condExp = ~(f.z | sv);
            4'h2: condExp = f.z | sv;
            4'hB: condExp = ~f.c & ~f.z;
            default: condExp = f.c | f.z;
        endcase
    endfunction : condExp

    // ************************************************************
    // checks and bus helpers
    // ************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        seq_u.xfer(1'b1, a, d, be, q);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        seq_u.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    endtask : rd

    task automatic runAdd(input logic [7:0] op, input logic [7:0] dst, input logic [7:0] src,
                          input logic [5:0] fin);
        bca_pkg::bca_sum_s e;
        logic [31:0]       q;
        int                b0;
        int                want;
        e    = addExp(dst, src, op[4] & fin[0]);
        want = (op[3:0] == `BCA_LO_RR) ? `BCA_CYC_SHORT - 1 : `BCA_CYC_LONG - 1;
        wr(`BCA_OFS_OPND, {16'h0000, src, dst}, 4'h3);
        wr(`BCA_OFS_FLAG, {26'h000_0000, fin}, 4'h1);
        b0 = busyCycles;
        wr(`BCA_OFS_CMD, {24'h00_0000, op}, 4'h1);
        rd(`BCA_OFS_OPND, q);
        check(q[15:0], {src, e.res});
        rd(`BCA_OFS_FLAG, q);
        check(q[5:0], e.flg);
        check(flagsOut, e.flg);
        rd(`BCA_OFS_STAT, q);
        check(q[3:2], 2'b00);
        check(busyCycles - b0, want);
    endtask : runAdd

    task automatic runJmp(input logic [3:0] cc, input logic dir, input logic [5:0] fin);
        logic [31:0] q;
        logic        t;
        int          b0;
        t = condExp(cc, bca_pkg::bca_flags_s'(fin));
        wr(`BCA_OFS_FLAG, {26'h000_0000, fin}, 4'h1);
        b0 = busyCycles;
        wr(`BCA_OFS_CMD, {24'h00_0000, cc, dir ? `BCA_LO_DIR : `BCA_LO_REL}, 4'h1);
        check(jumpTaken, t);
        rd(`BCA_OFS_STAT, q);
        check(q[3:1], {2'b10, t});
        rd(`BCA_OFS_FLAG, q);
        check(q[5:0], fin);
        check(busyCycles - b0, `BCA_CYC_JMP - 1);
    endtask : runJmp

    task automatic report_and_stop;
        if (seqHung !== 1'b0) begin
            fail_count++;
            $display("[ERR] %0t bus access never answered", $time);
        end
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [31:0] q;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] s;
        logic [7:0]  badOps [4];
        int          r;
        int          f;
        int          i;
        int          b0;
        badOps = '{8'h00, 8'h07, 8'h21, 8'hFF};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        check({jumpTaken, execBusy, flagsOut}, 8'h00);
        for (i = 0; i < 16; i++) begin
            rd(i[3:0], q);
            check(q, 32'h0000_0000);
        end
        // carry-in into nibble, overflow, zero with carry
        runAdd(8'h02, 8'h7F, 8'h01, 6'h3F);
        runAdd(8'h12, 8'h0F, 8'h00, 6'h01);
        runAdd(8'h16, 8'hFF, 8'h00, 6'h01);
        runAdd(8'h04, 8'h80, 8'h80, 6'h00);
        runAdd(8'h13, 8'h10, 8'h03, 6'h01);
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            f = $random(seed);
            runAdd({3'b000, r[8], 4'h2 + 4'(r[15:0] % 5)}, r[23:16], r[31:24], f[5:0]);
        end
        for (i = 0; i < 9; i++) begin
            a = (i == 0) ? 16'h00FF : 16'($random(seed));
            b = (i == 0) ? 16'h0001 : 16'($random(seed));
            s = a + b;
            runAdd(8'h02, a[7:0], b[7:0], 6'h00);
            wr(`BCA_OFS_OPND, {16'h0000, b[15:8], a[15:8]}, 4'h3);
            wr(`BCA_OFS_CMD, 32'h0000_0012, 4'h1);
            rd(`BCA_OFS_OPND, q);
            check(q[7:0], s[15:8]);
        end
        for (i = 0; i < 256; i++) begin
            r = $random(seed);
            runJmp(i[3:0], i[0] ^ i[4], {r[1:0], i[7:4]});
        end
        wr(`BCA_OFS_OPND, 32'h0000_5AC3, 4'h3);
        for (i = 0; i < 4; i++) begin
            b0 = busyCycles;
            wr(`BCA_OFS_CMD, {24'h00_0000, badOps[i]}, 4'h1);
            rd(`BCA_OFS_STAT, q);
            check(q[2], 1'b1);
            rd(`BCA_OFS_CMD, q);
            check(q[7:0], badOps[i]);
            rd(`BCA_OFS_OPND, q);
            check(q[15:0], 16'h5AC3);
            check(busyCycles - b0, `BCA_CYC_BAD - 1);
        end
        // unmapped writes dropped, single byte lane honoured
        wr(4'h1, 32'hFFFF_FFFF, 4'hF);
        wr(4'hD, 32'hFFFF_FFFF, 4'hF);
        wr(`BCA_OFS_OPND, 32'hFFFF_FF00, 4'h1);
        rd(`BCA_OFS_OPND, q);
        check(q[15:0], 16'h5A00);
        rd(4'h2, q);
        check(q, 32'h0000_0000);
        report_and_stop();
    end
endmodule : bca_core_tb
